// ### logic/iodf_pkg.sv
package iodf_pkg;
  localparam int IN_BYTES      = 6;
  localparam int OUT_BYTES     = 4;
  localparam int MPG_BYTES     = 3;
  localparam int BYTE_W        = 8;
  localparam int ADDR_W        = 16;
  localparam int GROUP_W       = 5;
  localparam int PATH_W        = 4;
  localparam int INFO_W        = 2;
  localparam logic [GROUP_W-1:0] GROUP_MAX  = 5'h17;
  localparam logic [7:0]        ALARM_TYPE = 8'h00;
  localparam logic [7:0]        SLOT_OUT   = 8'h01;
  localparam logic [7:0]        ZERO_BYTE  = 8'h00;
  localparam logic [7:0]        ONES_BYTE  = 8'hff;
  // alarm report state machine, gray from idle to send to wait, not on the way back
  typedef enum logic [1:0] {
    IODF_IDLE = 2'b00,
    IODF_SEND = 2'b01,
    IODF_WAIT = 2'b11
  } iodf_state_e;
endpackage

// ### logic/iodf_byte_guard.sv
`timescale 1ns/1ps
module iodf_byte_guard
  import iodf_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic        ovc_i,
  input  wire logic        ovt_i,
  input  wire logic [7:0]  gnd_i,
  output logic      [7:0]  drv_o,
  output logic             trip_o,
  output logic      [7:0]  alarm_o
);
  logic [7:0] drv_ff;
  logic       trip_ff;
  logic [7:0] alarm_ff;

  // -----------------------------------------
  // byte protection
  // -----------------------------------------
  // (R4) whole byte off
  // (R10) resume when clear
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      trip_ff <= 1'b0;
      drv_ff  <= ZERO_BYTE;
    end
    else
    begin
      trip_ff <= ovc_i | ovt_i;
      drv_ff  <= (ovc_i | ovt_i) ? ZERO_BYTE : cmd_i;
    end
  end

  // -----------------------------------------
  // per point fault bits
  // -----------------------------------------
  // (R7) bit k flags point k
  // (R10) bits follow live fault
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      alarm_ff <= ZERO_BYTE;
    else
      alarm_ff <= gnd_i;
  end

  assign drv_o   = drv_ff;
  assign trip_o  = trip_ff;
  assign alarm_o = alarm_ff;
endmodule

// ### logic/iodf_do_fault.sv
// What this block does
// (R1) The host places six input bytes and four output bytes in slot one.
// (R2) The three handwheel bytes form one slot, never addressed singly.
// (R3) The host ladder_sequence_controller ignores handwheel slot bytes.
// (R4) A driver fault holds its whole output byte off while it lasts.
// (R5) A driver fault raises no alarm stop and other work continues.
// (R6) Ground faults per output point go to the host relay area.
// (R7) Each alarm byte has one bit per output bit, one meaning fault.
// (R8) Alarm numbers 0 to 3 name output bytes base plus 0 to 3, type 0.
// (R9) Group, path and address fields follow link and host assignment.
// (R10) Alarm bits clear and outputs resume once the fault is gone.
`timescale 1ns/1ps
module iodf_do_fault
  import iodf_pkg::*;
#(
  parameter int NBYTES = OUT_BYTES
)
(
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  input  wire logic [NBYTES*8-1:0]      out_cmd_i,
  input  wire logic [NBYTES-1:0]        ovc_i,
  input  wire logic [NBYTES-1:0]        ovt_i,
  input  wire logic [NBYTES*8-1:0]      gnd_fault_i,
  input  wire logic [iodf_pkg::GROUP_W-1:0] group_i,
  input  wire logic [iodf_pkg::PATH_W-1:0]  path_i,
  input  wire logic [iodf_pkg::ADDR_W-1:0]  output_base_address_i,
  input  wire logic                     rpt_ready_i,
  output logic      [NBYTES*8-1:0]      out_drv_o,
  output logic      [NBYTES-1:0]        byte_trip_o,
  output logic      [NBYTES*8-1:0]      alarm_data_o,
  output logic                          rpt_valid_o,
  output logic      [7:0]               rpt_type_o,
  output logic      [iodf_pkg::GROUP_W-1:0] rpt_group_o,
  output logic      [iodf_pkg::PATH_W-1:0]  rpt_path_o,
  output logic      [7:0]               rpt_slot_o,
  output logic      [iodf_pkg::INFO_W-1:0]  rpt_info_o,
  output logic      [iodf_pkg::ADDR_W-1:0]  rpt_addr_o,
  output logic      [7:0]               rpt_data_o
);
  import iodf_pkg::*;

  logic [NBYTES*8-1:0] alarm_w;
  logic [NBYTES*8-1:0] sent_ff;
  logic [INFO_W-1:0]   scan_ff;
  iodf_state_e         state_ff;
  logic [INFO_W-1:0]   info_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [7:0]          data_ff;
  logic [GROUP_W-1:0]  group_ff;
  logic [PATH_W-1:0]   path_ff;
  logic [7:0]          cur_alarm;
  logic [NBYTES-1:0]   chg_w;
  logic                latch_w;
  logic                step_w;
  logic [INFO_W-1:0]   nxt_scan;
  logic [GROUP_W-1:0]  group_clamp;

  // -----------------------------------------
  // one guard per output byte
  // -----------------------------------------
  // (R5) no stop, other bytes go on
  // own guard per byte, so a trip never spills into the next byte
  for (genvar b = 0; b < NBYTES; b++)
  begin : g_byte
    iodf_byte_guard u_guard (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .cmd_i   (out_cmd_i[b*8 +: 8]),
      .ovc_i   (ovc_i[b]),
      .ovt_i   (ovt_i[b]),
      .gnd_i   (gnd_fault_i[b*8 +: 8]),
      .drv_o   (out_drv_o[b*8 +: 8]),
      .trip_o  (byte_trip_o[b]),
      .alarm_o (alarm_w[b*8 +: 8])
    );
  end

  assign alarm_data_o = alarm_w;
  assign cur_alarm    = alarm_w[scan_ff*8 +: 8];

  // -----------------------------------------
  // per byte change flags
  // -----------------------------------------
  // (R10) a cleared byte differs from its sent copy too
  // flags are live, so a fault that comes and goes between scans is missed
  for (genvar b = 0; b < NBYTES; b++)
  begin : g_chg
    assign chg_w[b] = (alarm_w[b*8 +: 8] != sent_ff[b*8 +: 8]);
  end

  // -----------------------------------------
  // status alarm reporting
  // -----------------------------------------
  // a byte that differs from its sent copy is reported, clearing too,
  // so the host copy never goes stale
  assign latch_w  = (state_ff == IODF_IDLE) && chg_w[scan_ff];
  assign nxt_scan = (scan_ff == INFO_W'(NBYTES-1)) ? '0 : scan_ff + 1'b1;
  // (R9) group clamped to range
  assign group_clamp = (group_i > GROUP_MAX) ? GROUP_MAX : group_i;

  // -----------------------------------------
  // scan advance
  // -----------------------------------------
  // scan moves past a quiet byte, or once a report is done
  always_comb
  begin
    step_w = 1'b0;
    case (state_ff)
      IODF_IDLE: step_w = !latch_w;
      IODF_WAIT: step_w = 1'b1;
      default:   step_w = 1'b0;
    endcase
  end

  // (R6) report to relay area
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      state_ff <= IODF_IDLE;
    else
    begin
      case (state_ff)
        IODF_IDLE:
        begin
          if (latch_w)
            state_ff <= IODF_SEND;
        end
        IODF_SEND:
        begin
          // held until the relay area takes it
          if (rpt_ready_i)
            state_ff <= IODF_WAIT;
        end
        IODF_WAIT:
        begin
          // this cycle and the idle one after it part two reports
          state_ff <= IODF_IDLE;
        end
        default:
        begin
          state_ff <= IODF_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------
  // byte scan pointer
  // -----------------------------------------
  // one byte per idle cycle: cheap, but latency grows with NBYTES
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      scan_ff <= '0;
    else if (step_w)
      scan_ff <= nxt_scan;
  end

  // -----------------------------------------
  // copy of what the host was sent
  // -----------------------------------------
  // copied at the latch, so a change during a send is caught next pass
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      sent_ff <= '0;
    else if (latch_w)
      sent_ff[scan_ff*8 +: 8] <= cur_alarm;
  end

  // -----------------------------------------
  // report fields
  // -----------------------------------------
  // caught at the latch and held still while valid is up
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      info_ff <= '0;
      addr_ff <= '0;
      data_ff <= ZERO_BYTE;
    end
    else if (latch_w)
    begin
      // (R8) info number is byte index
      info_ff <= scan_ff;
      addr_ff <= output_base_address_i + ADDR_W'(scan_ff);
      // (R7) one bit per output point
      data_ff <= cur_alarm;
    end
  end

  // -----------------------------------------
  // link fields
  // -----------------------------------------
  // (R9) fields from link setup
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      group_ff <= '0;
      path_ff  <= '0;
    end
    else if (latch_w)
    begin
      group_ff <= group_clamp;
      path_ff  <= path_i;
    end
  end

  // -----------------------------------------
  // report outputs
  // -----------------------------------------
  // type and slot never vary: every output byte sits in the first slot
  // valid comes from state, so it drops the cycle after the accept
  assign rpt_valid_o = (state_ff == IODF_SEND);
  assign rpt_type_o  = ALARM_TYPE;
  assign rpt_slot_o  = SLOT_OUT;
  assign rpt_group_o = group_ff;
  assign rpt_path_o  = path_ff;
  assign rpt_info_o  = info_ff;
  assign rpt_addr_o  = addr_ff;
  assign rpt_data_o  = data_ff;
endmodule

// ### verification/iodf_do_fault_sva.sv
`timescale 1ns/1ps
module iodf_do_fault_sva
  import iodf_pkg::*;
#(parameter int NBYTES = 4)
(
  input logic                mclk_i,
  input logic                rst_i,
  input logic [NBYTES*8-1:0] out_cmd_i,
  input logic [NBYTES-1:0]   ovc_i,
  input logic [NBYTES-1:0]   ovt_i,
  input logic [NBYTES*8-1:0] gnd_fault_i,
  input logic [GROUP_W-1:0]  group_i,
  input logic [PATH_W-1:0]   path_i,
  input logic [ADDR_W-1:0]   output_base_address_i,
  input logic                rpt_ready_i,
  input logic [NBYTES*8-1:0] out_drv_o,
  input logic [NBYTES-1:0]   byte_trip_o,
  input logic [NBYTES*8-1:0] alarm_data_o,
  input logic                rpt_valid_o,
  input logic [7:0]          rpt_type_o,
  input logic [GROUP_W-1:0]  rpt_group_o,
  input logic [PATH_W-1:0]   rpt_path_o,
  input logic [7:0]          rpt_slot_o,
  input logic [INFO_W-1:0]   rpt_info_o,
  input logic [ADDR_W-1:0]   rpt_addr_o
);
  // ----------------------------------------
  // output and report checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_accept;
    rpt_valid_o && rpt_ready_i;
  endsequence
  for (genvar b = 0; b < NBYTES; b++)
  begin : g_byte
    a_trip_off:
      assert property (!$past(rst_i) && $past(ovc_i[b] | ovt_i[b]) |->
        byte_trip_o[b] && out_drv_o[8*b+:8] == 8'h00)
      else $error("faulted byte not held off");
    a_follow_cmd:
      assert property (!$past(rst_i) && !$past(ovc_i[b] | ovt_i[b]) |->
        !byte_trip_o[b] && out_drv_o[8*b+:8] == $past(out_cmd_i[8*b+:8]))
      else $error("healthy byte not following command");
  end
  a_alarm_live:
    assert property (!$past(rst_i) |-> alarm_data_o == $past(gnd_fault_i))
    else $error("alarm bits not matching ground faults");
  a_rpt_hold:
    assert property (rpt_valid_o && !rpt_ready_i |=> rpt_valid_o &&
      $stable(rpt_addr_o) && $stable(rpt_info_o) && $stable(rpt_group_o))
    else $error("report dropped or changed before accept");
  a_rpt_gap:
    assert property (s_accept |=> !rpt_valid_o)
    else $error("no gap after accepted report");
  a_rpt_addr:
    assert property (rpt_valid_o |-> rpt_type_o == 8'h00 &&
      rpt_slot_o == 8'h01 && rpt_addr_o == output_base_address_i + rpt_info_o)
    else $error("report address fields wrong");
  a_rpt_group:
    assert property (rpt_valid_o |-> rpt_path_o == path_i &&
      rpt_group_o == (group_i > 5'h17 ? 5'h17 : group_i))
    else $error("report group or path wrong");
endmodule
bind iodf_do_fault iodf_do_fault_sva #(.NBYTES(NBYTES)) u_sva (.*);

// ### verification/iodf_relay_model.sv
`timescale 1ns/1ps
module iodf_relay_model
#(parameter logic [15:0] BASE = 16'h0040)
(
  input  logic        mclk_i,
  input  logic        slow_i,
  output logic        ready_o,
  output logic [15:0] base_o
);
  // ----------------------------------------
  // host relay area
  // ----------------------------------------
  // host picks base
  assign base_o = BASE;
  logic rdy_q = 1'b0;
  // stalls alternate so held reports get exercised
  always @(negedge mclk_i) rdy_q <= slow_i ? !rdy_q : 1'b1;
  assign ready_o = rdy_q;
endmodule

// ### verification/iodf_do_fault_tb.sv
`timescale 1ns/1ps
module iodf_do_fault_tb;
  import iodf_pkg::*;
  logic        mclk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
  logic [31:0] out_cmd_i = 32'h0, gnd_fault_i = 32'h0, out_drv_o, alarm_data_o;
  logic [3:0]  ovc_i = 4'h0, ovt_i = 4'h0, path_i = 4'h0, byte_trip_o;
  logic [3:0]  rpt_path_o;
  logic [4:0]  group_i = 5'h0, rpt_group_o;
  logic [15:0] output_base_address_i, rpt_addr_o;
  logic [7:0]  rpt_type_o, rpt_slot_o, rpt_data_o, e;
  logic [1:0]  rpt_info_o;
  logic        rpt_ready_i, rpt_valid_o;
  logic [67:0] q_out[$];
  logic [34:0] q_rpt[$];
  logic [31:0] seed = 32'h8ba41ffc;
  int          n_mismatch = 0, cmp_count = 0;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  always #25 mclk_i = !mclk_i;
  iodf_do_fault uut (.*);
  iodf_relay_model u_host (.mclk_i(mclk_i), .slow_i(slow),
    .ready_o(rpt_ready_i), .base_o(output_base_address_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string name, logic [67:0] seen, logic [67:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task step(logic [31:0] c, logic [31:0] g, logic [3:0] f, logic [3:0] h);
    logic [31:0] x;
    @(negedge mclk_i);
    {out_cmd_i, gnd_fault_i, ovc_i, ovt_i} = {c, g, f, h};
    slow = seed[7];
    for (int b = 0; b < 4; b++)
      x[8*b+:8] = (f[b] | h[b]) ? 8'h00 : c[8*b+:8];
    q_out.push_back({f | h, x, g});
  endtask
  task report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    if (rpt_valid_o && rpt_ready_i)
    begin
      chk("report", {rpt_group_o, rpt_path_o, rpt_info_o, rpt_addr_o,
        rpt_data_o}, q_rpt.pop_front());
      chk("report kind", {rpt_type_o, rpt_slot_o}, 68'h0001);
    end
    #5;
    if (q_out.size() > 0)
      chk("outputs", {byte_trip_o, out_drv_o, alarm_data_o},
        q_out.pop_front());
  end
  initial
  begin
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (200) step(rnd(), 32'h0, 4'(rnd() & rnd()), 4'(rnd() & rnd()));
    for (int b = 0; b < 4; b++)
    begin
      group_i = 5'(rnd());
      path_i = 4'(rnd());
      for (int v = 0; v < 2; v++)
      begin
        e = v ? 8'h00 : 8'(rnd() | 32'h1);
        q_rpt.push_back({group_i > 5'h17 ? 5'h17 : group_i, path_i, 2'(b),
          output_base_address_i + 16'(b), e});
        repeat (30) step(out_cmd_i, 32'(e) << 8 * b, 4'h0, 4'h0);
      end
    end
    repeat (2) @(negedge mclk_i);
    chk("pending reports", q_rpt.size(), 68'h0);
    chk("pending outputs", q_out.size(), 68'h0);
    report_and_stop();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
